//--- design/dio_pkg.sv
// constants and state type for the digital i/o card interrupt and port logic
package dio_pkg;

    // register offsets in host i/o space
    localparam logic [2:0] DIO_OFF_PORT_A  = 3'h0;
    localparam logic [2:0] DIO_OFF_PORT_B  = 3'h1;
    localparam logic [2:0] DIO_OFF_PORT_C  = 3'h2;
    localparam logic [2:0] DIO_OFF_SRC_EN  = 3'h5;
    localparam logic [2:0] DIO_OFF_MODE    = 3'h6;
    localparam logic [2:0] DIO_OFF_PENDING = 3'h7;

    // interrupt_mode_control field positions
    localparam int DIO_MODE_LOW_LSB  = 0;
    localparam int DIO_MODE_HIGH_LSB = 2;
    localparam int DIO_MODE_EXT_LSB  = 4;
    localparam int DIO_MODE_EXT_EN   = 6;
    localparam int DIO_MODE_EXT_FLAG = 7;

    // trigger mode codes
    localparam logic [1:0] DIO_TRIG_LEVEL_LOW  = 2'h0;
    localparam logic [1:0] DIO_TRIG_LEVEL_HIGH = 2'h1;
    localparam logic [1:0] DIO_TRIG_EDGE_FALL  = 2'h2;
    localparam logic [1:0] DIO_TRIG_EDGE_RISE  = 2'h3;

    // sizes
    localparam int DIO_NUM_CHAN = 8;
    localparam int DIO_NUM_SRC  = 9;
    localparam int DIO_EXT_IDX  = 8;
    localparam int DIO_HIGH_FIRST = 4;

    // reset values
    localparam logic [7:0] DIO_LATCH_RST = 8'hff;
    localparam logic [7:0] DIO_BYTE_ZERO = 8'h00;
    localparam logic [6:0] DIO_MODE_RST  = 7'h00;

    typedef struct packed {
        logic [7:0]              latch_a;
        logic [7:0]              latch_b;
        logic [7:0]              latch_c;
        logic [7:0]              src_en;
        logic [6:0]              mode;
        logic [7:0]              chan_pending;
        logic                    external_pending_flag;
        logic [DIO_NUM_SRC-1:0]  samp;
        logic [DIO_NUM_SRC-1:0]  prev;
        logic [7:0]              rdata;
        logic                    irq;
    } dio_state_t;

    localparam dio_state_t DIO_STATE_RST = '{
        latch_a:               DIO_LATCH_RST,
        latch_b:               DIO_LATCH_RST,
        latch_c:               DIO_LATCH_RST,
        src_en:                DIO_BYTE_ZERO,
        mode:                  DIO_MODE_RST,
        chan_pending:          DIO_BYTE_ZERO,
        external_pending_flag: 1'b0,
        samp:                  9'h000,
        prev:                  9'h000,
        rdata:                 DIO_BYTE_ZERO,
        irq:                   1'b0
    };

    // offset match, used by the write decode; the read decode cases on the address directly
    function automatic logic dio_hit(input logic [2:0] addr, input logic [2:0] off);
        dio_hit = (addr == off);
    endfunction

endpackage

//--- design/dio_trig_detect.sv
// trigger condition detector for one interrupt source
`timescale 1ns/1ps
`default_nettype none
module dio_trig_detect (
    // selection
    input  wire logic [1:0] mode_in,
    // sampled level now and one cycle earlier
    input  wire logic       cur_in,
    input  wire logic       prev_in,
    // condition present this cycle
    output logic            cond_out
);
    import dio_pkg::*;

    always_comb begin
        unique case (mode_in)
            DIO_TRIG_LEVEL_LOW:  cond_out = ~cur_in;            // R1
            DIO_TRIG_LEVEL_HIGH: cond_out = cur_in;             // R1
            DIO_TRIG_EDGE_FALL:  cond_out = prev_in & ~cur_in;  // R1 R23
            DIO_TRIG_EDGE_RISE:  cond_out = ~prev_in & cur_in;  // R1 R23
        endcase
    end

endmodule
`default_nettype wire

//--- design/dio_irq_port.sv
// interrupt logic and port latches of the 24-channel digital i/o card
//
// Functional notes
// R1: mode field 00 low level, 01 high level, 10 falling edge, 11 rising edge.
// R2: external pin trigger mode comes from mode control bits 5:4 at offset 6.
// R3: mode control bits 3:2 set the trigger of sources four to seven.
// R4: mode control bits 1:0 set the trigger of sources zero to three.
// R5: mode control bit 6 enables the external source when one.
// R6: reading mode control bit 7 gives external pending status, not stored data.
// R7: writing one to mode control bit 7 acknowledges the external source.
// R8: reading offset 7 returns channel pending vector, bit n for source n.
// R9: pending bit sets when enabled source meets its condition, holds until acked.
// R10: request stays up while pending vector nonzero or a condition remains.
// R11: write to offset 7 acknowledges source n by bit n; not readable back.
// R12: acknowledge clears a pending bit only if its condition has gone.
// R13: after acknowledge, request rises again if any pending bit stays set.
// R14: host sets channel as input, enables it and picks mode before use.
// R15: request is raised whenever external pending status reads one.
// R16: external pending clears only on acknowledge with its condition gone.
// R17: output channel latch one turns module off, latch zero turns it on.
// R18: port read gives pin level where latch is one, zero where masked.
// R19: host always writes ones to input channel bits on port writes.
// R20: persisting active level re-raises the request right after acknowledge.
// R21: enable register at offset 5 enables source n by bit n.
// R22: interrupt channel stays readable as an ordinary input.
// R23: edges from sampled level against previous sample; levels sampled first.
// R24: reset clears enables, modes and pending bits; no request until set up.
// R25: host request is the or of all pending channel bits and external pending.
`timescale 1ns/1ps
`default_nettype none
module dio_irq_port (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    // host i/o byte access
    input  wire logic [2:0]  bus_addr_in,
    input  wire logic        bus_wr_in,
    input  wire logic        bus_rd_in,
    input  wire logic [7:0]  bus_wdata_in,
    output logic      [7:0]  bus_rdata_out,
    // connector
    input  wire logic [23:0] port_pin_in,
    input  wire logic        ext_pin_in,
    output logic      [23:0] port_latch_out,
    output logic      [23:0] port_module_on_out,
    // host interrupt request
    output logic             irq_out
);
    import dio_pkg::*;

    dio_state_t             q_r;
    dio_state_t             q_nxt;
    logic [DIO_NUM_SRC-1:0] cond;
    logic [1:0]             src_mode [DIO_NUM_SRC];
    logic [1:0]             external_trigger_mode;
    logic [1:0]             high_group_trigger_mode;
    logic [1:0]             low_group_trigger_mode;
    logic                   external_source_enable;
    logic                   external_clear_strobe;
    logic [7:0]             chan_ack;
    logic [7:0]             chan_cond;
    logic                   ext_cond;
    logic                   wr_mode;
    logic                   wr_ack;
    logic [23:0]            latch_all;

    assign external_trigger_mode   = q_r.mode[DIO_MODE_EXT_LSB +: 2];   // R2
    assign high_group_trigger_mode = q_r.mode[DIO_MODE_HIGH_LSB +: 2];  // R3
    assign low_group_trigger_mode  = q_r.mode[DIO_MODE_LOW_LSB +: 2];   // R4
    assign external_source_enable  = q_r.mode[DIO_MODE_EXT_EN];         // R5

    // one detector per source; nibbles chosen independently
    genvar gi;
    generate
        for (gi = 0; gi < DIO_NUM_SRC; gi++) begin : g_src
            if (gi == DIO_EXT_IDX) begin : g_ext
                assign src_mode[gi] = external_trigger_mode;             // R2
            end else if (gi >= DIO_HIGH_FIRST) begin : g_hi
                assign src_mode[gi] = high_group_trigger_mode;           // R3
            end else begin : g_lo
                assign src_mode[gi] = low_group_trigger_mode;            // R4
            end
            dio_trig_detect u_det (
                .mode_in  (src_mode[gi]),
                .cur_in   (q_r.samp[gi]),
                .prev_in  (q_r.prev[gi]),
                .cond_out (cond[gi])
            );
        end
    endgenerate

    assign chan_cond = cond[DIO_NUM_CHAN-1:0];
    assign ext_cond  = cond[DIO_EXT_IDX];

    assign wr_mode = bus_wr_in & dio_hit(bus_addr_in, DIO_OFF_MODE);
    assign wr_ack  = bus_wr_in & dio_hit(bus_addr_in, DIO_OFF_PENDING);
    assign chan_ack = wr_ack ? bus_wdata_in : DIO_BYTE_ZERO;                      // R11
    assign external_clear_strobe = wr_mode & bus_wdata_in[DIO_MODE_EXT_FLAG];     // R7

    always_comb begin
        q_nxt = q_r;
        // one sample stage, then the previous sample for edges
        q_nxt.samp = {ext_pin_in, port_pin_in[23:16]};                            // R23
        q_nxt.prev = q_r.samp;                                                    // R23

        // latch and configuration writes
        if (bus_wr_in && dio_hit(bus_addr_in, DIO_OFF_PORT_A)) begin
            q_nxt.latch_a = bus_wdata_in;
        end
        if (bus_wr_in && dio_hit(bus_addr_in, DIO_OFF_PORT_B)) begin
            q_nxt.latch_b = bus_wdata_in;
        end
        if (bus_wr_in && dio_hit(bus_addr_in, DIO_OFF_PORT_C)) begin
            q_nxt.latch_c = bus_wdata_in;
        end
        if (bus_wr_in && dio_hit(bus_addr_in, DIO_OFF_SRC_EN)) begin
            q_nxt.src_en = bus_wdata_in;                                          // R21
        end
        if (wr_mode) begin
            // bit 7 is an acknowledge, never stored
            q_nxt.mode = bus_wdata_in[6:0];                                       // R7
        end

        // set beats clear: an ack racing a new condition keeps the bit
        q_nxt.chan_pending = (q_r.chan_pending & ~(chan_ack & ~chan_cond))        // R12
                           | (q_r.src_en & chan_cond);                            // R9 R20
        q_nxt.external_pending_flag =
            (q_r.external_pending_flag & ~(external_clear_strobe & ~ext_cond))    // R16
            | (external_source_enable & ext_cond);                                // R5 R9

        // request follows pending state, including re-raise after ack
        q_nxt.irq = (|q_nxt.chan_pending) | q_nxt.external_pending_flag;          // R10 R13 R15 R25

        // read answer registered, one cycle after the strobe
        if (bus_rd_in) begin
            unique case (bus_addr_in)
                DIO_OFF_PORT_A:  q_nxt.rdata = port_pin_in[7:0] & q_r.latch_a;    // R18
                DIO_OFF_PORT_B:  q_nxt.rdata = port_pin_in[15:8] & q_r.latch_b;   // R18
                DIO_OFF_PORT_C:  q_nxt.rdata = port_pin_in[23:16] & q_r.latch_c;  // R18 R22
                DIO_OFF_SRC_EN:  q_nxt.rdata = q_r.src_en;
                DIO_OFF_MODE:    q_nxt.rdata = {q_r.external_pending_flag, q_r.mode}; // R6
                DIO_OFF_PENDING: q_nxt.rdata = q_r.chan_pending;                  // R8
                default:         q_nxt.rdata = DIO_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q_r <= DIO_STATE_RST;                                                 // R24
        end else begin
            q_r <= q_nxt;
        end
    end

    assign latch_all          = {q_r.latch_c, q_r.latch_b, q_r.latch_a};
    assign port_latch_out     = latch_all;
    // sink drive is active low on the latch
    assign port_module_on_out = ~latch_all;                                       // R17
    assign bus_rdata_out      = q_r.rdata;
    assign irq_out            = q_r.irq;

    // checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);

    sequence s_ext_ack;
        wr_mode && bus_wdata_in[DIO_MODE_EXT_FLAG];
    endsequence

    sequence s_ext_quiet;
        !ext_cond;
    endsequence

    sequence s_chan_ack_quiet;
        wr_ack && ((bus_wdata_in & ~chan_cond) != 8'h00);
    endsequence

    a_ack_clears_idle: assert property (                                          // R12
        s_chan_ack_quiet |=> ((q_r.chan_pending & $past(bus_wdata_in & ~chan_cond)) == 8'h00))
        else $error("acked idle channel stayed pending");

    a_ack_keeps_live: assert property (                                           // R20
        (wr_ack && ((bus_wdata_in & chan_cond & q_r.src_en) != 8'h00))
        |=> ((q_r.chan_pending & $past(bus_wdata_in & chan_cond & q_r.src_en))
             == $past(bus_wdata_in & chan_cond & q_r.src_en)) ##0 irq_out)
        else $error("live channel lost pending or request on ack");

    a_cond_sets_pend: assert property (                                           // R9
        ((chan_cond & q_r.src_en) != 8'h00)
        |=> ((q_r.chan_pending & $past(chan_cond & q_r.src_en))
             == $past(chan_cond & q_r.src_en)))
        else $error("enabled condition did not set pending");

    a_pend_holds_noack: assert property (                                         // R9
        (!wr_ack && !srst_in) |=> ((q_r.chan_pending & $past(q_r.chan_pending))
                                   == $past(q_r.chan_pending)))
        else $error("pending bit dropped without ack");

    a_irq_is_or: assert property (                                                // R25
        irq_out == ((|q_r.chan_pending) || q_r.external_pending_flag))
        else $error("request differs from pending or");

    a_ext_ack_clear: assert property (                                            // R16
        (s_ext_ack and s_ext_quiet) |=> !q_r.external_pending_flag)
        else $error("external pending not cleared by ack");

    a_ext_disabled: assert property (                                             // R5
        (!external_source_enable && !q_r.external_pending_flag && !wr_mode)
        |=> !q_r.external_pending_flag)
        else $error("disabled external source went pending");

    a_ext_rise_seq: assert property (                                             // R23
        (external_source_enable && external_trigger_mode == DIO_TRIG_EDGE_RISE
         && !wr_mode && !ext_pin_in) ##1 (ext_pin_in && !wr_mode)
        |=> ##1 q_r.external_pending_flag ##0 irq_out)
        else $error("rising external edge not caught in two cycles");

    a_mode_readback: assert property (                                            // R6
        (bus_rd_in && bus_addr_in == DIO_OFF_MODE)
        |=> bus_rdata_out == {$past(q_r.external_pending_flag), $past(q_r.mode)})
        else $error("mode control read wrong");

    a_port_masked: assert property (                                              // R18
        (bus_rd_in && bus_addr_in == DIO_OFF_PORT_C)
        |=> bus_rdata_out == $past(port_pin_in[23:16] & q_r.latch_c))
        else $error("port read not masked by latch");

    a_reset_quiet: assert property (                                              // R24
        @(posedge sys_clk_in) disable iff (1'b0)
        srst_in |=> (!irq_out && q_r.mode == 7'h00 && q_r.src_en == 8'h00
                     && q_r.chan_pending == 8'h00))
        else $error("reset left configuration or request");

    sequence s_ext_fall_armed;
        external_source_enable && external_trigger_mode == DIO_TRIG_EDGE_FALL
        && !wr_mode && ext_pin_in;
    endsequence

    sequence s_ext_pin_drops;
        !ext_pin_in && !wr_mode;
    endsequence

    a_ext_fall_seq: assert property (                                             // R1 R23
        s_ext_fall_armed ##1 s_ext_pin_drops |=> ##1 q_r.external_pending_flag)
        else $error("falling external edge not caught in two cycles");

    a_pend_readback: assert property (                                            // R8
        (bus_rd_in && bus_addr_in == DIO_OFF_PENDING)
        |=> bus_rdata_out == $past(q_r.chan_pending))
        else $error("pending vector read wrong");

    a_ack_not_stored: assert property (                                           // R11
        (wr_ack && !bus_rd_in) |=> ($stable(q_r.src_en) && $stable(q_r.mode)
                                    && $stable(q_r.latch_c) && $stable(q_r.rdata)))
        else $error("acknowledge write was stored");

    a_mode_write: assert property (                                               // R7
        wr_mode |=> q_r.mode == $past(bus_wdata_in[6:0]))
        else $error("mode write stored wrong bits");

    a_enable_write: assert property (                                             // R21
        (bus_wr_in && bus_addr_in == DIO_OFF_SRC_EN)
        |=> q_r.src_en == $past(bus_wdata_in))
        else $error("enable write did not land");

    a_chan_disabled: assert property (                                            // R21
        !srst_in |=> ((q_r.chan_pending & ~$past(q_r.chan_pending) & ~$past(q_r.src_en))
                      == 8'h00))
        else $error("disabled channel went pending");

    a_ext_irq: assert property (                                                  // R15
        q_r.external_pending_flag |-> irq_out)
        else $error("external pending without request");

    a_ext_cond_sets: assert property (                                            // R5 R9
        (external_source_enable && ext_cond) |=> q_r.external_pending_flag)
        else $error("enabled external condition did not set pending");

    a_ext_holds: assert property (                                                // R16
        (q_r.external_pending_flag && !(external_clear_strobe && !ext_cond))
        |=> q_r.external_pending_flag)
        else $error("external pending dropped without ack");

    a_latch_drive: assert property (                                              // R17
        (bus_wr_in && bus_addr_in == DIO_OFF_PORT_A)
        |=> (port_latch_out[7:0] == $past(bus_wdata_in)
             && port_module_on_out[7:0] == ~$past(bus_wdata_in)))
        else $error("port latch or module drive wrong");

    a_low_level_high: assert property (                                           // R4 R1
        (low_group_trigger_mode == DIO_TRIG_LEVEL_HIGH) |-> chan_cond[3:0] == q_r.samp[3:0])
        else $error("low group high level condition wrong");

    a_high_fall_edge: assert property (                                           // R3 R1
        (high_group_trigger_mode == DIO_TRIG_EDGE_FALL)
        |-> chan_cond[7:4] == (q_r.prev[7:4] & ~q_r.samp[7:4]))
        else $error("high group falling edge condition wrong");

    a_ext_level_low: assert property (                                            // R2 R1
        (external_trigger_mode == DIO_TRIG_LEVEL_LOW) |-> ext_cond == !q_r.samp[DIO_EXT_IDX])
        else $error("external low level condition wrong");

    a_sample_pipe: assert property (                                              // R23
        !srst_in |=> (q_r.samp == $past({ext_pin_in, port_pin_in[23:16]})
                      && q_r.prev == $past(q_r.samp)))
        else $error("pin sample stages out of step");

    a_reset_latch: assert property (                                              // R24 R17
        @(posedge sys_clk_in) disable iff (1'b0)
        srst_in |=> (port_latch_out == 24'hffffff && port_module_on_out == 24'h000000))
        else $error("reset left a module switched on");

endmodule
`default_nettype wire

//--- verif/dio_host_model.sv
// host side model: byte reads and writes at card offsets
`timescale 1ns/1ps
`default_nettype none
module dio_host_model (
    // clock
    input  wire logic       clk_in,
    // bus toward the card
    output logic      [2:0] addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output logic      [7:0] wdata_out,
    input  wire logic [7:0] rdata_in
);
    initial begin
        addr_out  = 3'h0;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 8'h00;
    end
    // one strobe cycle, then address and data scrambled so stale values never pass
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out    = 1'b0;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask
    // read data is taken once the strobe edge has updated it
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out   = 1'b1;
        @(posedge clk_in);
        #1;
        d        = rdata_in;
        rd_out   = 1'b0;
        addr_out = ~a;
    endtask
endmodule
`default_nettype wire

//--- verif/dio_irq_port_tb.sv
// self-checking bench for the i/o card interrupt and port logic
`timescale 1ns/1ps
`default_nettype none
module dio_irq_port_tb;
    import dio_pkg::*;
    logic        sys_clk_in;
    logic        srst_in;
    logic [2:0]  bus_addr;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_wdata;
    logic [7:0]  bus_rdata;
    logic [23:0] port_pin;
    logic        ext_pin;
    logic [23:0] port_latch;
    logic [23:0] module_on;
    logic        irq;
    int          err_count;
    int          num_checks;

    dio_irq_port dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .bus_addr_in(bus_addr),
        .bus_wr_in(bus_wr), .bus_rd_in(bus_rd), .bus_wdata_in(bus_wdata),
        .bus_rdata_out(bus_rdata), .port_pin_in(port_pin), .ext_pin_in(ext_pin),
        .port_latch_out(port_latch), .port_module_on_out(module_on), .irq_out(irq));
    dio_host_model host (.clk_in(sys_clk_in), .addr_out(bus_addr), .wr_out(bus_wr),
        .rd_out(bus_rd), .wdata_out(bus_wdata), .rdata_in(bus_rdata));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        check({16'h0000, v}, {16'h0000, exp});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // source 0 = channel 0 (low group), 1 = channel 4 (high group), 2 = external pin
    task automatic set_pin(input int s, input logic v);
        case (s)
            0: port_pin[16] = v;
            1: port_pin[20] = v;
            default: ext_pin = v;
        endcase
    endtask
    task automatic expect_pend(input int s, input logic [7:0] mv, input logic p);
        logic [7:0] vec;
        vec = (s == 0) ? {7'h00, p} : {3'h0, p, 4'h0};
        check({23'h0, irq}, {23'h0, p});
        if (s == 2) begin
            rd_chk(DIO_OFF_MODE, {p, mv[6:0]});
        end else begin
            rd_chk(DIO_OFF_MODE, mv);
            rd_chk(DIO_OFF_PENDING, vec);
        end
    endtask
    task automatic ack(input int s, input logic [7:0] mv);
        if (s == 2) host.wr(DIO_OFF_MODE, mv | 8'h80);
        else host.wr(DIO_OFF_PENDING, (s == 0) ? 8'h01 : 8'h10);
    endtask
    // one trigger code on one source: fire, ack while held, release, ack
    task automatic run_src(input int s, input logic [1:0] c);
        logic [7:0] mv;
        logic [7:0] en;
        logic       act;
        act = c[0];
        mv = (s == 0) ? {6'h00, c} : (s == 1) ? {4'h0, c, 2'h0} : {2'h1, c, 4'h0};
        en = (s == 0) ? 8'h01 : (s == 1) ? 8'h10 : 8'h00;
        set_pin(s, ~act);
        host.wr(DIO_OFF_SRC_EN, en);
        host.wr(DIO_OFF_MODE, mv);
        wait_cyc(3);
        ack(s, mv);
        expect_pend(s, mv, 1'b0);
        set_pin(s, act);
        wait_cyc(2);
        expect_pend(s, mv, 1'b1);
        if (s == 0) rd_chk(DIO_OFF_PORT_C, port_pin[23:16]);
        ack(s, mv);
        expect_pend(s, mv, ~c[1]);
        set_pin(s, ~act);
        wait_cyc(3);
        ack(s, mv);
        expect_pend(s, mv, 1'b0);
    endtask

    initial begin
        err_count = 0;
        num_checks = 0;
        repeat (20000) @(posedge sys_clk_in);
        err_count++;
        tally_and_finish();
    end

    initial begin
        srst_in  = 1'b1;
        port_pin = 24'h000000;
        ext_pin  = 1'b0;
        wait_cyc(10);
        srst_in = 1'b0;
        check(port_latch, 24'hffffff);
        check(module_on, 24'h000000);
        check({23'h0, irq}, 24'h0);
        rd_chk(DIO_OFF_SRC_EN, 8'h00);
        rd_chk(DIO_OFF_MODE, 8'h00);
        rd_chk(DIO_OFF_PENDING, 8'h00);
        // port latches, drive and masking
        port_pin[15:0] = 16'ha5ff;
        host.wr(DIO_OFF_PORT_A, 8'h55);
        host.wr(DIO_OFF_PORT_B, 8'h5f);
        host.wr(3'h3, 8'h12);
        check({8'h00, port_latch[15:0]}, 24'h005f55);
        check({8'h00, module_on[15:0]}, 24'h00a0aa);
        rd_chk(DIO_OFF_PORT_A, 8'h55);
        rd_chk(DIO_OFF_PORT_B, 8'h05);
        rd_chk(3'h3, 8'h00);
        // disabled sources stay quiet, then two channels pend together
        host.wr(DIO_OFF_PORT_C, 8'hff);
        host.wr(DIO_OFF_MODE, 8'h05);
        port_pin[23:16] = 8'h11;
        wait_cyc(3);
        rd_chk(DIO_OFF_PENDING, 8'h00);
        check({23'h0, irq}, 24'h0);
        rd_chk(DIO_OFF_MODE, 8'h05);
        host.wr(DIO_OFF_SRC_EN, 8'h11);
        wait_cyc(2);
        rd_chk(DIO_OFF_PENDING, 8'h11);
        port_pin[16] = 1'b0;
        wait_cyc(3);
        host.wr(DIO_OFF_PENDING, 8'hff);
        rd_chk(DIO_OFF_PENDING, 8'h10);
        check({23'h0, irq}, 24'h1);
        port_pin[20] = 1'b0;
        wait_cyc(3);
        host.wr(DIO_OFF_PENDING, 8'h10);
        rd_chk(DIO_OFF_PENDING, 8'h00);
        check({23'h0, irq}, 24'h0);
        for (int s = 0; s < 3; s++) begin
            for (int c = 0; c < 4; c++) begin
                run_src(s, 2'(c));
            end
        end
        // second reset in mid-run, with a request standing
        host.wr(DIO_OFF_PORT_A, 8'h00);
        host.wr(DIO_OFF_SRC_EN, 8'h01);
        wait_cyc(2);
        check({23'h0, irq}, 24'h1);
        srst_in = 1'b1;
        wait_cyc(2);
        srst_in = 1'b0;
        check(port_latch, 24'hffffff);
        check({23'h0, irq}, 24'h0);
        rd_chk(DIO_OFF_PENDING, 8'h00);
        rd_chk(DIO_OFF_MODE, 8'h00);
        rd_chk(DIO_OFF_SRC_EN, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
